// ==== rtl/fl_pkg.sv ====
// constants and state types shared by the fan table entry block
package fl_pkg;

  // ---------------------------------------------------------------
  // bus geometry and register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam int         ADDR_W      = 12;
  localparam int         TEMP_W      = 11;
  localparam logic [7:0] IDX_UNLOCK  = 8'h4A;
  localparam logic [7:0] IDX_OFFSET  = 8'h4E;
  localparam logic [7:0] IDX_LIM7    = 8'h5C;
  localparam logic [7:0] IDX_DUTY7   = 8'h5D;
  localparam logic [7:0] IDX_LIM8    = 8'h5E;
  localparam logic [7:0] IDX_DUTY8   = 8'h5F;
  localparam logic [7:0] IDX_CTRL    = 8'h70;
  localparam logic [7:0] IDX_STATUS  = 8'h71;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LIMIT   = 8'h7F;
  localparam logic [7:0] RST_DUTY    = 8'h3F;
  localparam logic [7:0] RST_UNLOCK  = 8'h00;
  localparam logic [7:0] RST_OFFSET  = 8'h00;
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_FANDUTY = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int UNLOCK_BIT      = 5;
  localparam int CTRL_TEMP_HIRES = 0;
  localparam int CTRL_DUTY_HIRES = 1;
  localparam int CTRL_PWM_22K    = 2;
  localparam int STAT_HIT_LO     = 0;
  localparam int STAT_DUTY_LO    = 8;
  localparam int STAT_TEMP_LO    = 16;

  // ---------------------------------------------------------------
  // bus answers and channel states
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FL_W_WAIT = 2'b00,
    FL_W_RESP = 2'b01
  } fl_wr_state_t;

  typedef enum logic [1:0] {
    FL_R_IDLE = 2'b00,
    FL_R_DATA = 2'b01
  } fl_rd_state_t;

endpackage

// ==== rtl/fl_entry_cmp.sv ====
// threshold comparison for one fan table entry
`timescale 1ns/1ns
module fl_entry_cmp
  import fl_pkg::*;
(
  input  wire logic [7:0]        limit,
  input  wire logic [7:0]        offset,
  input  wire logic              temp_hires,
  input  wire logic [TEMP_W-1:0] remote_temp,
  output wire logic              over
);

  // ---------------------------------------------------------------
  // threshold in half degrees (degrees in low mode), widened so the offset cannot wrap
  // ---------------------------------------------------------------
  logic [9:0] thr_w;
  logic [9:0] temp_w;

  // limit is unsigned in both modes; low mode drops the top bit
  always_comb begin
    if (temp_hires) begin
      thr_w  = {2'b00, limit} + {1'b0, offset, 1'b0};
      temp_w = {1'b0, remote_temp[TEMP_W-1:2]};
    end else begin
      thr_w  = {3'b000, limit[6:0]} + {2'b00, offset};
      temp_w = {2'b00, remote_temp[TEMP_W-1:3]};
    end
  end

  assign over = temp_w > thr_w;

endmodule

// ==== rtl/fl_duty_sel.sv ====
// duty value that one table entry hands to the fan output
`timescale 1ns/1ns
module fl_duty_sel
  import fl_pkg::*;
(
  input  wire logic [7:0] duty,
  input  wire logic       duty_hires,
  input  wire logic       pwm_22k,
  output wire logic [7:0] value
);

  // ---------------------------------------------------------------
  // extension bits count only in high mode at 22.5 kHz
  // ---------------------------------------------------------------
  assign value = (duty_hires && pwm_22k) ? duty
                                         : {2'b00, duty[5:0]};

endmodule

// ==== rtl/fl_top.sv ====
// fan table entries seven and eight behind an axi4-lite slave
`timescale 1ns/1ns
// Notes on behaviour
// - entries always readable; writes land only while unlock register bit 5 is set
// - low temperature mode: limit top bit reads as zero
// - high temperature mode: 8-bit limit in half degrees, 9 temperature bits compared
// - low temperature mode: 7-bit limit in degrees, 8 temperature bits compared
// - temperature above entry limit selects that entry's duty for the fan output, entry eight's when both are exceeded
// - limits are positive only; sign bit taken as zero
// - low duty mode: duty extension bits read as zero
// - high duty mode: extension and base bits form one 8-bit duty
// - extension bits act only while 22.5 kHz pwm is selected
// - otherwise only the six base bits supply the fan duty
module fl_top
  import fl_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  output wire logic [1:0]        bresp,
  output wire logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output wire logic              arready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  output wire logic              rvalid,
  input  wire logic              rready,
  input  wire logic [TEMP_W-1:0] remote_temp,
  input  wire logic              conv_done,
  output wire logic [7:0]        fan_duty,
  output wire logic [1:0]        table_hit
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fl_wr_state_t      wst_q, wst_d;
  fl_rd_state_t      rst_q, rst_d;
  logic              aw_hold_q, aw_hold_d;
  logic              w_hold_q, w_hold_d;
  logic [7:0]        awidx_q, awidx_d;
  logic [7:0]        wbyte_q, wbyte_d;
  logic              wstrb0_q, wstrb0_d;
  logic [1:0]        bresp_q, bresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  logic [7:0]        unlock_q, unlock_d;
  logic [7:0]        offset_q, offset_d;
  logic [7:0]        ctrl_q, ctrl_d;
  logic [7:0]        lim7_q, lim7_d;
  logic [7:0]        duty7_q, duty7_d;
  logic [7:0]        lim8_q, lim8_d;
  logic [7:0]        duty8_q, duty8_d;
  logic [1:0]        hit_q, hit_d;
  logic [7:0]        fan_duty_q, fan_duty_d;
  logic [TEMP_W-1:0] temp_q, temp_d;
  logic [1:0]        over_w;
  logic [7:0]        sel7_w;
  logic [7:0]        sel8_w;
  logic              wr_fire;
  logic              ar_fire;
  logic              temp_hires;
  logic              duty_hires;
  logic              pwm_22k;

  assign temp_hires = ctrl_q[CTRL_TEMP_HIRES];
  assign duty_hires = ctrl_q[CTRL_DUTY_HIRES];
  assign pwm_22k    = ctrl_q[CTRL_PWM_22K];

  // ---------------------------------------------------------------
  // read view helpers
  // ---------------------------------------------------------------
  // storage keeps all bits; only the view is masked, so a mode flip restores them
  function automatic logic [7:0] fl_rd_limit(input logic [7:0] v, input logic hires);
    fl_rd_limit = hires ? v : {1'b0, v[6:0]};
  endfunction

  function automatic logic [7:0] fl_rd_duty(input logic [7:0] v, input logic hires);
    fl_rd_duty = hires ? v : {2'b00, v[5:0]};
  endfunction

  function automatic logic fl_mapped(input logic [7:0] idx);
    case (idx)
      IDX_UNLOCK, IDX_OFFSET, IDX_LIM7, IDX_DUTY7,
      IDX_LIM8, IDX_DUTY8, IDX_CTRL, IDX_STATUS: fl_mapped = 1'b1;
      default:                                   fl_mapped = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // write channels: address and data held apart, joined afterwards
  // ---------------------------------------------------------------
  assign awready = (wst_q == FL_W_WAIT) && !aw_hold_q;
  assign wready  = (wst_q == FL_W_WAIT) && !w_hold_q;
  assign bvalid  = (wst_q == FL_W_RESP);
  assign bresp   = bresp_q;
  assign wr_fire = (wst_q == FL_W_WAIT) && aw_hold_q && w_hold_q;

  // next state of the write side
  always_comb begin
    wst_d     = wst_q;
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awidx_d   = awidx_q;
    wbyte_d   = wbyte_q;
    wstrb0_d  = wstrb0_q;
    bresp_d   = bresp_q;
    case (wst_q)
      FL_W_WAIT: begin
        if (awvalid && awready) begin
          aw_hold_d = 1'b1;
          awidx_d   = awaddr[9:2];
        end
        if (wvalid && wready) begin
          w_hold_d = 1'b1;
          wbyte_d  = wdata[7:0];
          wstrb0_d = wstrb[0];
        end
        if (wr_fire) begin
          wst_d   = FL_W_RESP;
          bresp_d = fl_mapped(awidx_q) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      FL_W_RESP: begin
        if (bready) begin
          wst_d     = FL_W_WAIT;
          aw_hold_d = 1'b0;
          w_hold_d  = 1'b0;
        end
      end
      default: wst_d = FL_W_WAIT;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q     <= FL_W_WAIT;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awidx_q   <= 8'h00;
      wbyte_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      wst_q     <= wst_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awidx_q   <= awidx_d;
      wbyte_q   <= wbyte_d;
      wstrb0_q  <= wstrb0_d;
      bresp_q   <= bresp_d;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // only lane 0 carries data; a locked table write still answers okay
  always_comb begin
    unlock_d = unlock_q;
    offset_d = offset_q;
    ctrl_d   = ctrl_q;
    lim7_d   = lim7_q;
    duty7_d  = duty7_q;
    lim8_d   = lim8_q;
    duty8_d  = duty8_q;
    if (wr_fire && wstrb0_q) begin
      case (awidx_q)
        IDX_UNLOCK: unlock_d = wbyte_q;
        IDX_OFFSET: offset_d = wbyte_q;
        IDX_CTRL:   ctrl_d   = wbyte_q;
        IDX_LIM7:   if (unlock_q[UNLOCK_BIT]) lim7_d  = wbyte_q;
        IDX_DUTY7:  if (unlock_q[UNLOCK_BIT]) duty7_d = wbyte_q;
        IDX_LIM8:   if (unlock_q[UNLOCK_BIT]) lim8_d  = wbyte_q;
        IDX_DUTY8:  if (unlock_q[UNLOCK_BIT]) duty8_d = wbyte_q;
        default:    unlock_d = unlock_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_q <= RST_UNLOCK;
      offset_q <= RST_OFFSET;
      ctrl_q   <= RST_CTRL;
      lim7_q   <= RST_LIMIT;
      duty7_q  <= RST_DUTY;
      lim8_q   <= RST_LIMIT;
      duty8_q  <= RST_DUTY;
    end else begin
      unlock_q <= unlock_d;
      offset_q <= offset_d;
      ctrl_q   <= ctrl_d;
      lim7_q   <= lim7_d;
      duty7_q  <= duty7_d;
      lim8_q   <= lim8_d;
      duty8_q  <= duty8_d;
    end
  end

  // ---------------------------------------------------------------
  // read channel: one word answered the cycle after the address
  // ---------------------------------------------------------------
  assign arready = (rst_q == FL_R_IDLE);
  assign ar_fire = arvalid && arready;
  assign rvalid  = (rst_q == FL_R_DATA);
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  always_comb begin
    rst_d   = rst_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rst_q)
      FL_R_IDLE: begin
        if (ar_fire) begin
          rst_d   = FL_R_DATA;
          rresp_d = fl_mapped(araddr[9:2]) ? RESP_OKAY : RESP_SLVERR;
          case (araddr[9:2])
            IDX_UNLOCK: rdata_d = {24'h000000, unlock_q};
            IDX_OFFSET: rdata_d = {24'h000000, offset_q};
            IDX_CTRL:   rdata_d = {24'h000000, ctrl_q};
            IDX_LIM7:   rdata_d = {24'h000000, fl_rd_limit(lim7_q, temp_hires)};
            IDX_DUTY7:  rdata_d = {24'h000000, fl_rd_duty(duty7_q, duty_hires)};
            IDX_LIM8:   rdata_d = {24'h000000, fl_rd_limit(lim8_q, temp_hires)};
            IDX_DUTY8:  rdata_d = {24'h000000, fl_rd_duty(duty8_q, duty_hires)};
            IDX_STATUS: rdata_d = {5'h00, temp_q, fan_duty_q, 6'h00, hit_q};
            default:    rdata_d = 32'h00000000;
          endcase
        end
      end
      FL_R_DATA: begin
        if (rready) begin
          rst_d = FL_R_IDLE;
        end
      end
      default: rst_d = FL_R_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_q   <= FL_R_IDLE;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      rst_q   <= rst_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // table lookup
  // ---------------------------------------------------------------
  fl_entry_cmp u_cmp7 (
    .limit       (lim7_q),
    .offset      (offset_q),
    .temp_hires  (temp_hires),
    .remote_temp (remote_temp),
    .over        (over_w[0])
  );

  fl_entry_cmp u_cmp8 (
    .limit       (lim8_q),
    .offset      (offset_q),
    .temp_hires  (temp_hires),
    .remote_temp (remote_temp),
    .over        (over_w[1])
  );

  fl_duty_sel u_sel7 (
    .duty       (duty7_q),
    .duty_hires (duty_hires),
    .pwm_22k    (pwm_22k),
    .value      (sel7_w)
  );

  fl_duty_sel u_sel8 (
    .duty       (duty8_q),
    .duty_hires (duty_hires),
    .pwm_22k    (pwm_22k),
    .value      (sel8_w)
  );

  // sampled once per conversion; between conversions the duty holds,
  // and with neither entry exceeded the earlier duty stays in force
  always_comb begin
    hit_d      = hit_q;
    temp_d     = temp_q;
    fan_duty_d = fan_duty_q;
    if (conv_done) begin
      hit_d  = over_w;
      temp_d = remote_temp;
      if (over_w[1]) begin
        fan_duty_d = sel8_w;
      end else if (over_w[0]) begin
        fan_duty_d = sel7_w;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q      <= 2'b00;
      temp_q     <= {TEMP_W{1'b0}};
      fan_duty_q <= RST_FANDUTY;
    end else begin
      hit_q      <= hit_d;
      temp_q     <= temp_d;
      fan_duty_q <= fan_duty_d;
    end
  end

  assign fan_duty  = fan_duty_q;
  assign table_hit = hit_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // reference compares written out apart from the compare units
  logic              chk_hi7_w;
  logic              chk_lo7_w;
  logic              chk_sgn7_w;

  assign chk_hi7_w  = {1'b0, remote_temp[TEMP_W-1:2]}
                      > ({2'b00, lim7_q} + {1'b0, offset_q, 1'b0});
  assign chk_lo7_w  = {2'b00, remote_temp[TEMP_W-1:3]}
                      > ({3'b000, lim7_q[6:0]} + {2'b00, offset_q});
  assign chk_sgn7_w = remote_temp[TEMP_W-1:3] > {1'b0, lim7_q[6:0]};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_locked_write_ignored: assert property (
    (wr_fire && !unlock_q[UNLOCK_BIT]) |=> ($stable(lim7_q) && $stable(duty7_q)
      && $stable(lim8_q) && $stable(duty8_q)))
    else $error("table entry changed while locked");

  a_unlocked_write_lands: assert property (
    (wr_fire && wstrb0_q && unlock_q[UNLOCK_BIT] && awidx_q == IDX_LIM8)
      |=> (lim8_q == $past(wbyte_q)))
    else $error("unlocked limit write did not land");

  a_low_limit_top_zero: assert property (
    (ar_fire && araddr[9:2] == IDX_LIM7 && !temp_hires) |=> (rvalid && rdata_q[7]
      == 1'b0 && rdata_q[6:0] == $past(lim7_q[6:0])))
    else $error("low mode limit read shows top bit");

  a_hires_compare: assert property (
    (conv_done && temp_hires) |=> (hit_q[0] == $past(chk_hi7_w)))
    else $error("high mode comparison wrong");

  a_lowres_compare: assert property (
    (conv_done && !temp_hires) |=> (hit_q[0] == $past(chk_lo7_w)))
    else $error("low mode comparison wrong");

  a_sign_bit_ignored: assert property (
    (conv_done && !temp_hires && lim7_q[7] && offset_q == 8'h00) |=> (hit_q[0]
      == $past(chk_sgn7_w)))
    else $error("limit top bit acted as sign");

  a_entry_eight_duty: assert property (
    (conv_done && over_w[1]) |=> (fan_duty_q == $past(sel8_w)) && hit_q[1])
    else $error("fan duty not taken from entry eight");

  a_hires_duty_join: assert property (
    (conv_done && !over_w[1] && over_w[0] && duty_hires && pwm_22k)
      |=> (fan_duty_q == $past(duty7_q)))
    else $error("high mode duty not eight bits");

  a_ext_needs_22k: assert property (
    (conv_done && (over_w != 2'b00) && !pwm_22k) |=> (fan_duty_q[7:6] == 2'b00))
    else $error("extension bits active off 22.5 kHz");

  a_low_duty_base: assert property (
    (conv_done && !over_w[1] && over_w[0] && !duty_hires)
      |=> (fan_duty_q == {2'b00, $past(duty7_q[5:0])}))
    else $error("low mode duty not base bits");

  a_low_duty_read: assert property (
    (ar_fire && araddr[9:2] == IDX_DUTY8 && !duty_hires) |=> (rdata_q[7:6] == 2'b00))
    else $error("low mode duty read shows extension");

  a_duty_holds_idle: assert property (
    (!conv_done) [*2] |=> ($stable(fan_duty_q) && $stable(hit_q)))
    else $error("fan duty moved without a conversion");

  a_bvalid_holds: assert property (
    (bvalid && !bready) |=> bvalid)
    else $error("write response dropped early");

  c_locked_write:   cover property (wr_fire && !unlock_q[UNLOCK_BIT]);
  c_unlocked_write: cover property (wr_fire && unlock_q[UNLOCK_BIT] && awidx_q == IDX_DUTY7);
  c_hit_eight:      cover property (conv_done && over_w == 2'b11);
  c_hires_22k_hit:  cover property (conv_done && over_w[0] && duty_hires && pwm_22k);

endmodule

// ==== bench/tb.sv ====
// self-checking bench for the fan table entry block
`timescale 1ns/1ns
module tb
  import fl_pkg::*;
();
  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  logic [TEMP_W-1:0] remote_temp;
  logic              conv_done;
  logic [7:0]        fan_duty;
  logic [1:0]        table_hit;
  int                err_count;
  int                n_checks;
  int                cyc;

  fl_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .remote_temp(remote_temp), .conv_done(conv_done), .fan_duty(fan_duty),
    .table_hit(table_hit));

  // ---------------------------------------------------------------
  // clock, timeout and verdict
  // ---------------------------------------------------------------
  always #4 aclk = ~aclk;

  // whole run needs well under two thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  // aw and w offered together, each released once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic       ad;
    logic       wd;
    logic       b;
    logic [1:0] resp;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      if (awvalid && awready) ad = 1'b1;
      if (wvalid && wready) wd = 1'b1;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end while (!(ad && wd));
    do begin
      @(negedge aclk);
      b    = bvalid;
      resp = bresp;
      @(posedge aclk);
    end while (!b);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    wr(idx, d, 4'h1, RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    logic        a;
    logic        b;
    logic [31:0] data;
    logic [1:0]  resp;
    @(posedge aclk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      a = arvalid && arready;
      @(posedge aclk);
    end while (!a);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      b    = rvalid;
      data = rdata;
      resp = rresp;
      @(posedge aclk);
    end while (!b);
    rready <= 1'b0;
    chk("rdata", e, data);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  // one conversion pulse, then the fan result one cycle later
  task automatic conv(input logic [TEMP_W-1:0] t, input logic [1:0] eh, input logic [7:0] ed);
    @(posedge aclk);
    remote_temp <= t;
    conv_done   <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
    @(negedge aclk);
    chk("table_hit", {30'h0, eh}, {30'h0, table_hit});
    chk("fan_duty", {24'h0, ed}, {24'h0, fan_duty});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("fan_duty", 32'h0, {24'h0, fan_duty});
    rd(IDX_LIM7, 32'h7F, RESP_OKAY);
    rd(IDX_DUTY7, 32'h3F, RESP_OKAY);
    rd(IDX_LIM8, 32'h7F, RESP_OKAY);
    rd(IDX_DUTY8, 32'h3F, RESP_OKAY);
    rd(IDX_OFFSET, 32'h00, RESP_OKAY);
  endtask

  // locked write ignored, then masked reads in both modes
  task automatic t_lock();
    wreg(IDX_LIM7, 8'h10);
    rd(IDX_LIM7, 32'h7F, RESP_OKAY);
    wreg(IDX_UNLOCK, 8'h20);
    wreg(IDX_LIM7, 8'hB2);
    wreg(IDX_DUTY7, 8'hD2);
    rd(IDX_LIM7, 32'h32, RESP_OKAY);
    rd(IDX_DUTY7, 32'h12, RESP_OKAY);
    wreg(IDX_CTRL, 8'h03);
    rd(IDX_LIM7, 32'hB2, RESP_OKAY);
    rd(IDX_DUTY7, 32'hD2, RESP_OKAY);
    wreg(IDX_CTRL, 8'h00);
    wr(IDX_LIM7, 8'h44, 4'h0, RESP_OKAY);
    rd(IDX_LIM7, 32'h32, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 8'h55, 4'h1, RESP_SLVERR);
  endtask

  // low resolution: stored 0xB2 compares as 50 degrees
  task automatic t_lowres();
    wreg(IDX_LIM8, 8'h64);
    wreg(IDX_DUTY8, 8'h34);
    conv(11'd400, 2'b00, 8'h00);
    conv(11'd408, 2'b01, 8'h12);
    conv(11'd807, 2'b01, 8'h12);
    conv(11'd808, 2'b11, 8'h34);
    conv(11'd400, 2'b00, 8'h34);
    // a new reading without the pulse must not move the result
    @(posedge aclk);
    remote_temp <= 11'd808;
    repeat (3) @(posedge aclk);
    chk("table_hit", 32'h0, {30'h0, table_hit});
  endtask

  // high resolution: limits in half degrees, bit 7 counts
  task automatic t_hires();
    wreg(IDX_CTRL, 8'h01);
    wreg(IDX_LIM7, 8'h65);
    wreg(IDX_LIM8, 8'hC9);
    conv(11'd404, 2'b00, 8'h34);
    conv(11'd408, 2'b01, 8'h12);
    conv(11'd804, 2'b01, 8'h12);
    conv(11'd808, 2'b11, 8'h34);
  endtask

  // offset lifts 127 degrees to an effective 143
  task automatic t_offset();
    wreg(IDX_CTRL, 8'h00);
    wreg(IDX_OFFSET, 8'h10);
    wreg(IDX_LIM7, 8'h7F);
    wreg(IDX_LIM8, 8'h7F);
    conv(11'd1144, 2'b00, 8'h34);
    conv(11'd1152, 2'b11, 8'h34);
    rd(IDX_STATUS, 32'h04803403, RESP_OKAY);
    wreg(IDX_STATUS, 8'hFF);
    rd(IDX_STATUS, 32'h04803403, RESP_OKAY);
    wreg(IDX_OFFSET, 8'h00);
  endtask

  // extension bits count only with high duty mode and 22.5 kHz together
  task automatic t_duty();
    logic [7:0] c;
    wreg(IDX_LIM8, 8'h00);
    wreg(IDX_DUTY8, 8'hC5);
    for (int i = 0; i < 4; i++) begin
      c = 8'(i * 2);
      wreg(IDX_CTRL, c);
      conv(11'd8, 2'b10, (c == 8'h06) ? 8'hC5 : 8'h05);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    aclk        = 1'b0;
    aresetn     = 1'b0;
    awaddr      = '0;
    awvalid     = 1'b0;
    wdata       = 32'h0;
    wstrb       = 4'h0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    araddr      = '0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    remote_temp = '0;
    conv_done   = 1'b0;
    err_count   = 0;
    n_checks    = 0;
    cyc         = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset();
    t_lock();
    t_lowres();
    t_hires();
    t_offset();
    t_duty();
    end_of_test();
  end
endmodule
